/* File: rtl/swif_pkg.sv */
// shared constants and types of the sleep and wake flag block
package swif_pkg;
	// ********************************************************
	// register map, word aligned byte offsets
	// ********************************************************
	localparam logic [7:0] OFS_FLAGS1    = 8'h00;
	localparam logic [7:0] OFS_FLAGS2    = 8'h04;
	localparam logic [7:0] OFS_FLAGS3    = 8'h08;
	localparam logic [7:0] OFS_ENABLE1   = 8'h0c;
	localparam logic [7:0] OFS_ENABLE2   = 8'h10;
	localparam logic [7:0] OFS_ENABLE3   = 8'h14;
	localparam logic [7:0] OFS_GLOBAL    = 8'h18;
	localparam logic [7:0] OFS_STATUS    = 8'h1c;
	localparam logic [7:0] OFS_REGULATOR = 8'h20;
	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int BIT_T1_GATE   = 7;
	localparam int BIT_ADC_DONE  = 6;
	localparam int BIT_T2_MATCH  = 1;
	localparam int BIT_T1_OVF    = 0;
	localparam int BIT_NUM_OSC   = 2;
	localparam int BIT_CELL2     = 1;
	localparam int BIT_CELL1     = 0;
	localparam int BIT_GIE       = 7;
	localparam int BIT_PERIPH_IRQ_ENABLE      = 6;
	localparam int BIT_TIME_OUT  = 4;
	localparam int BIT_PWR_DOWN  = 3;
	localparam int BIT_VREG_PM   = 1;
	localparam int BIT_VREG_RSVD = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic       STATUS_RESET = 1'b1;
	// ********************************************************
	// regulator settle time on wake from low power sleep
	// ********************************************************
	localparam int SETTLE_NS     = 64;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;
	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		MODE_AWAKE  = 2'b00,
		MODE_ASLEEP = 2'b01,
		MODE_WAKING = 2'b10
	} swif_mode_t;
	typedef struct packed {
		logic timer1_gate_flag;
		logic adc_done_flag;
		logic timer2_match_flag;
		logic timer1_overflow_flag;
		logic num_osc_flag;
		logic logic_cell2_flag;
		logic logic_cell1_flag;
	} swif_evt_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} swif_wb_req_t;
endpackage : swif_pkg

/* File: rtl/swif_top.sv */
// sleep sequencer with peripheral request flags behind a wishbone slave
// Contract
// RQ1 - request flags set on their event regardless of any enable
// RQ2 - flags one: gate bit7, adc bit6, timer2 bit1, overflow bit0, rest zero
// RQ3 - flags two: oscillator flag bit2 only, other bits read zero
// RQ4 - flags three: cell2 bit1, cell1 bit0, bits 7 to 2 read zero
// RQ5 - software clears stale flags before enabling their interrupt
// RQ6 - sleep is entered only on the sleep instruction
// RQ7 - sleep entry clears power down status and sets time out status
// RQ8 - sleep entry clears the watchdog, which may keep counting
// RQ9 - cpu clock stops in sleep, low frequency oscillator keeps running
// RQ10 - timer1 keeps running in sleep on slow oscillator or external pin
// RQ11 - adc keeps running in sleep on its dedicated oscillator
// RQ12 - ports hold their drive state through sleep
// RQ13 - non watchdog resets act normally during sleep
// RQ14 - pin, brownout, power on resets reset; other wakes resume execution
// RQ15 - sleep instruction prefetches the following instruction
// RQ16 - interrupt wakes only when enabled, regardless of global enable
// RQ17 - after wake the next instruction runs before the vector
// RQ18 - watchdog cleared on every wake from sleep
// RQ19 - enabled flag already set makes sleep a no operation
// RQ20 - flag set during or after sleep: full entry then immediate wake
// RQ21 - software tests power down status to detect a skipped sleep
// RQ22 - regulator mode bit puts regulator in low power while asleep
// RQ23 - regulator mode is bit1, bit0 reserved and reads one
// RQ24 - peripheral enable gates any peripheral flag interrupt
// RQ25 - wake request is or of each flag and its enable
//
// Local design decisions: the register offsets and the Wishbone register port.
module swif_top
	import swif_pkg::*;
#(
	parameter int SETTLE_CNT = SETTLE_CYCLES
)(
	input  wire logic        CLK,            // system clock
	input  wire logic        RST,            // sync reset, high
	input  wire logic        WB_CYC,         // bus cycle
	input  wire logic        WB_STB,         // bus strobe
	input  wire logic        WB_WE,          // write enable
	input  wire logic [3:0]  WB_SEL,         // byte enables
	input  wire logic [7:0]  WB_ADR,         // byte address
	input  wire logic [31:0] WB_DAT_I,       // write data
	output logic      [31:0] WB_DAT_O,       // read data
	output logic             WB_ACK,         // bus acknowledge
	input  swif_evt_t        EVT,            // peripheral event pulses
	input  wire logic        SLEEP_EXEC,     // sleep instruction executing
	input  wire logic        INSTR_RETIRE,   // one instruction completed
	input  wire logic        EXT_IRQ_WAKE,   // external interrupt pending
	input  wire logic        WDT_TIMEOUT,    // watchdog expired
	input  wire logic        WDT_SLEEP_RUN,  // watchdog enabled in sleep
	input  wire logic        PIN_RESET_REQ,  // external reset pin
	input  wire logic        BROWNOUT_REQ,   // brownout reset
	input  wire logic        POWERON_REQ,    // power on reset
	input  wire logic [1:0]  T1_CLK_SEL,     // 0 sys, 1 slow osc, 2 ext pin
	input  wire logic        ADC_OSC_SEL,    // adc on dedicated osc
	output logic             CPU_CLK_EN,     // cpu clock gate
	output logic             LF_OSC_EN,      // slow oscillator enable
	output logic             T1_CLK_EN,      // timer1 clock gate
	output logic             ADC_CLK_EN,     // adc clock gate
	output logic             PORT_HOLD,      // freeze port drivers
	output logic             REG_LOW_POWER,  // regulator low power
	output logic             WDT_CLEAR,      // watchdog clear pulse
	output logic             WDT_RUN,        // watchdog allowed to count
	output logic             PREFETCH,       // fetch next address pulse
	output logic             RESUME,         // continue execution pulse
	output logic             CORE_RESET,     // device reset pulse
	output logic             IRQ_REQ,        // vector request to core
	output logic             ASLEEP          // in sleep
);
	// ********************************************************
	// state and elaboration check
	// ********************************************************
	typedef struct packed {
		swif_mode_t        mode;
		swif_evt_t         flags;
		swif_evt_t         enables;
		logic              global_irq_enable;
		logic              periph_irq_enable;
		logic              pd;
		logic              to;
		logic              regulator_power_mode_select;
		logic              ack;
		logic [31:0]       dat;
		logic              cpu_clk_en;
		logic              t1_clk_en;
		logic              adc_clk_en;
		logic              port_hold;
		logic              reg_low_power;
		logic              wdt_clear;
		logic              wdt_run;
		logic              prefetch;
		logic              resume;
		logic              core_reset;
		logic              irq_req;
		logic              irq_defer;
		logic              asleep;
		logic [CNT_W-1:0]  cnt;
	} swif_state_t;

	localparam swif_state_t STATE_RESET = '{
		mode: MODE_AWAKE, flags: swif_evt_t'(FLAGS_RESET[6:0]),
		enables: swif_evt_t'(FLAGS_RESET[6:0]), global_irq_enable: 1'b0, periph_irq_enable: 1'b0,
		pd: STATUS_RESET, to: STATUS_RESET, regulator_power_mode_select: 1'b0, ack: 1'b0,
		dat: 32'h0000_0000, cpu_clk_en: 1'b1, t1_clk_en: 1'b1,
		adc_clk_en: 1'b1, port_hold: 1'b0, reg_low_power: 1'b0,
		wdt_clear: 1'b0, wdt_run: 1'b1, prefetch: 1'b0, resume: 1'b0,
		core_reset: 1'b0, irq_req: 1'b0, irq_defer: 1'b0, asleep: 1'b0, cnt: '0};

	// refuse a settle count the counter cannot hold
	if (SETTLE_CNT < 1 || SETTLE_CNT >= (1 << CNT_W))
	begin : g_bad_settle
		$error("SETTLE_CNT out of range");
	end

	swif_state_t state_reg;
	swif_state_t state_next;

	// ********************************************************
	// decoding helpers
	// ********************************************************
	// byte image of one of the three flag or enable registers
	function automatic logic [7:0] to_byte(input swif_evt_t v, input logic [1:0] idx);
		logic [7:0] b;
		b = 8'h00;
		// RQ2 flags one layout
		if (idx == 2'd0)
		begin
			b[BIT_T1_GATE]  = v.timer1_gate_flag;
			b[BIT_ADC_DONE] = v.adc_done_flag;
			b[BIT_T2_MATCH] = v.timer2_match_flag;
			b[BIT_T1_OVF]   = v.timer1_overflow_flag;
		end
		// RQ3 flags two layout
		else if (idx == 2'd1)
			b[BIT_NUM_OSC] = v.num_osc_flag;
		// RQ4 flags three layout
		else if (idx == 2'd2)
		begin
			b[BIT_CELL2] = v.logic_cell2_flag;
			b[BIT_CELL1] = v.logic_cell1_flag;
		end
		return b;
	endfunction : to_byte

	// replace the bits of one register inside the packed group
	function automatic swif_evt_t from_byte(input swif_evt_t v, input logic [1:0] idx,
		input logic [7:0] b);
		swif_evt_t r;
		r = v;
		if (idx == 2'd0)
		begin
			r.timer1_gate_flag     = b[BIT_T1_GATE];
			r.adc_done_flag        = b[BIT_ADC_DONE];
			r.timer2_match_flag    = b[BIT_T2_MATCH];
			r.timer1_overflow_flag = b[BIT_T1_OVF];
		end
		else if (idx == 2'd1)
			r.num_osc_flag = b[BIT_NUM_OSC];
		else if (idx == 2'd2)
		begin
			r.logic_cell2_flag = b[BIT_CELL2];
			r.logic_cell1_flag = b[BIT_CELL1];
		end
		return r;
	endfunction : from_byte

	// ********************************************************
	// combinational terms
	// ********************************************************
	logic        bus_req;
	logic        bus_wr;
	logic        any_reset;
	logic        periph_pend;
	logic        wake_req;
	logic        t1_sleep_ok;
	logic [7:0]  rd_byte;
	logic [1:0]  grp;
	logic        is_flag;
	logic        is_enab;

	assign bus_req   = WB_CYC & WB_STB;
	// write lands on the edge where the master sees ack
	assign bus_wr    = bus_req & WB_WE & state_reg.ack & WB_SEL[0];
	assign any_reset = PIN_RESET_REQ | BROWNOUT_REQ | POWERON_REQ;
	// RQ25 or of flag and enable
	assign periph_pend = |(state_reg.flags & state_reg.enables);
	// RQ16 wake ignores global enable
	assign wake_req    = periph_pend | EXT_IRQ_WAKE;
	// RQ10 timer1 sources that live through sleep
	assign t1_sleep_ok = (T1_CLK_SEL == 2'd1) | (T1_CLK_SEL == 2'd2);

	// address decode for the flag and enable groups
	always_comb
	begin
		is_flag = (WB_ADR == OFS_FLAGS1) | (WB_ADR == OFS_FLAGS2) | (WB_ADR == OFS_FLAGS3);
		is_enab = (WB_ADR == OFS_ENABLE1) | (WB_ADR == OFS_ENABLE2) | (WB_ADR == OFS_ENABLE3);
		grp     = 2'd3;
		if (WB_ADR == OFS_FLAGS1 || WB_ADR == OFS_ENABLE1)
			grp = 2'd0;
		else if (WB_ADR == OFS_FLAGS2 || WB_ADR == OFS_ENABLE2)
			grp = 2'd1;
		else if (WB_ADR == OFS_FLAGS3 || WB_ADR == OFS_ENABLE3)
			grp = 2'd2;
	end

	// read mux, unmapped reads zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (is_flag)
			rd_byte = to_byte(state_reg.flags, grp);
		else if (is_enab)
			rd_byte = to_byte(state_reg.enables, grp);
		else if (WB_ADR == OFS_GLOBAL)
		begin
			rd_byte[BIT_GIE]  = state_reg.global_irq_enable;
			rd_byte[BIT_PERIPH_IRQ_ENABLE] = state_reg.periph_irq_enable;
		end
		else if (WB_ADR == OFS_STATUS)
		begin
			rd_byte[BIT_TIME_OUT] = state_reg.to;
			rd_byte[BIT_PWR_DOWN] = state_reg.pd;
		end
		// RQ23 reserved bit reads one
		else if (WB_ADR == OFS_REGULATOR)
		begin
			rd_byte[BIT_VREG_PM]   = state_reg.regulator_power_mode_select;
			rd_byte[BIT_VREG_RSVD] = 1'b1;
		end
	end

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		state_next            = state_reg;
		state_next.wdt_clear  = 1'b0;
		state_next.prefetch   = 1'b0;
		state_next.resume     = 1'b0;
		state_next.core_reset = 1'b0;

		// bus slave: ack one cycle after request, drop after one
		state_next.ack = bus_req & ~state_reg.ack;
		if (bus_req & ~state_reg.ack)
			state_next.dat = {24'h000000, rd_byte};
		if (bus_wr)
		begin
			if (is_flag)
				state_next.flags = from_byte(state_reg.flags, grp, WB_DAT_I[7:0]);
			else if (is_enab)
				state_next.enables = from_byte(state_reg.enables, grp, WB_DAT_I[7:0]);
			else if (WB_ADR == OFS_GLOBAL)
			begin
				state_next.global_irq_enable  = WB_DAT_I[BIT_GIE];
				state_next.periph_irq_enable = WB_DAT_I[BIT_PERIPH_IRQ_ENABLE];
			end
			else if (WB_ADR == OFS_REGULATOR)
				state_next.regulator_power_mode_select = WB_DAT_I[BIT_VREG_PM];
		end
		// RQ1 event sets flag, set beats clear
		state_next.flags = swif_evt_t'(state_next.flags | EVT);

		case (state_reg.mode)
			MODE_AWAKE:
			begin
				// RQ6 only the instruction starts sleep
				if (SLEEP_EXEC)
				begin
					// RQ15 prefetch the next address
					state_next.prefetch = 1'b1;
					// RQ19 pending wake turns sleep into nothing
					if (!wake_req)
					begin
						// RQ7 status on entry
						state_next.pd = 1'b0;
						state_next.to = 1'b1;
						// RQ8 clear watchdog on entry
						state_next.wdt_clear = 1'b1;
						state_next.wdt_run   = WDT_SLEEP_RUN;
						// RQ9 stop cpu clock
						state_next.cpu_clk_en = 1'b0;
						// RQ12 hold ports
						state_next.port_hold = 1'b1;
						// RQ10 timer1 gate in sleep
						state_next.t1_clk_en = t1_sleep_ok;
						// RQ11 adc gate in sleep
						state_next.adc_clk_en = ADC_OSC_SEL;
						// RQ22 regulator low power while asleep
						state_next.reg_low_power = state_reg.regulator_power_mode_select;
						state_next.mode = MODE_ASLEEP;
					end
				end
			end
			MODE_ASLEEP:
			begin
				state_next.t1_clk_en  = t1_sleep_ok;
				state_next.adc_clk_en = ADC_OSC_SEL;
				// RQ20 flag after entry wakes at once
				if (wake_req || (WDT_TIMEOUT && state_reg.wdt_run))
				begin
					// RQ18 clear watchdog on wake
					state_next.wdt_clear     = 1'b1;
					state_next.wdt_run       = 1'b1;
					state_next.reg_low_power = 1'b0;
					if (!wake_req)
						state_next.to = 1'b0;
					state_next.cnt  = state_reg.reg_low_power ?
						CNT_W'(SETTLE_CNT) : CNT_W'(1);
					state_next.mode = MODE_WAKING;
				end
			end
			MODE_WAKING:
			begin
				state_next.cnt = state_reg.cnt - CNT_W'(1);
				if (state_reg.cnt == CNT_W'(1))
				begin
					// RQ14 interrupt or watchdog wake resumes
					state_next.resume     = 1'b1;
					state_next.cpu_clk_en = 1'b1;
					state_next.port_hold  = 1'b0;
					state_next.t1_clk_en  = 1'b1;
					state_next.adc_clk_en = 1'b1;
					state_next.irq_defer  = 1'b1;
					state_next.mode       = MODE_AWAKE;
				end
			end
			default:
				state_next.mode = MODE_AWAKE;
		endcase

		// RQ17 one instruction runs before vectoring
		if (state_reg.irq_defer && INSTR_RETIRE)
			state_next.irq_defer = 1'b0;
		// RQ24 peripheral enable gates vectoring
		state_next.irq_req = (state_next.mode == MODE_AWAKE) & ~state_next.irq_defer &
			state_reg.global_irq_enable & (EXT_IRQ_WAKE | (state_reg.periph_irq_enable & periph_pend));
		// sleep indication registered together with the mode
		state_next.asleep = (state_next.mode != MODE_AWAKE);

		// RQ14 reset sources reset the device
		// RQ13 same path asleep or awake
		if (any_reset)
		begin
			state_next            = STATE_RESET;
			state_next.core_reset = 1'b1;
			state_next.wdt_clear  = 1'b1;
		end
	end

	// state register
	always_ff @(posedge CLK)
	begin
		if (RST)
			state_reg <= STATE_RESET;
		else
			state_reg <= state_next;
	end

	// outputs straight from the state register, except LF_OSC_EN which is tied high
	assign WB_DAT_O      = state_reg.dat;
	assign WB_ACK        = state_reg.ack;
	assign CPU_CLK_EN    = state_reg.cpu_clk_en;
	assign LF_OSC_EN     = 1'b1;  // RQ9 slow oscillator never stopped
	assign T1_CLK_EN     = state_reg.t1_clk_en;
	assign ADC_CLK_EN    = state_reg.adc_clk_en;
	assign PORT_HOLD     = state_reg.port_hold;
	assign REG_LOW_POWER = state_reg.reg_low_power;
	assign WDT_CLEAR     = state_reg.wdt_clear;
	assign WDT_RUN       = state_reg.wdt_run;
	assign PREFETCH      = state_reg.prefetch;
	assign RESUME        = state_reg.resume;
	assign CORE_RESET    = state_reg.core_reset;
	assign IRQ_REQ       = state_reg.irq_req;
	assign ASLEEP        = state_reg.asleep;

	// ********************************************************
	// assertions
	// ********************************************************
	property p_evt_sets;  // RQ1
		@(posedge CLK) disable iff (RST)
		(EVT.adc_done_flag && !any_reset) |=> state_reg.flags.adc_done_flag;
	endproperty
	a_evt_sets: assert property (p_evt_sets) else $error("event lost");
	property p_sleep_only_instr;  // RQ6
		@(posedge CLK) disable iff (RST)
		(state_reg.mode == MODE_AWAKE && !SLEEP_EXEC) |=> state_reg.mode == MODE_AWAKE;
	endproperty
	a_sleep_only_instr: assert property (p_sleep_only_instr) else $error("sleep w/o instr");
	property p_entry_status;  // RQ7
		@(posedge CLK) disable iff (RST)
		$rose(state_reg.mode == MODE_ASLEEP) |-> (!state_reg.pd && state_reg.to &&
			state_reg.wdt_clear && !state_reg.cpu_clk_en);
	endproperty
	a_entry_status: assert property (p_entry_status) else $error("bad sleep entry");
	property p_nop_sleep;  // RQ19
		@(posedge CLK) disable iff (RST)
		(state_reg.mode == MODE_AWAKE && SLEEP_EXEC && wake_req && !any_reset) |=>
			(state_reg.mode == MODE_AWAKE && !state_reg.wdt_clear &&
			state_reg.pd == $past(state_reg.pd));
	endproperty
	a_nop_sleep: assert property (p_nop_sleep) else $error("sleep not skipped");
	property p_prefetch;  // RQ15
		@(posedge CLK) disable iff (RST)
		(state_reg.mode == MODE_AWAKE && SLEEP_EXEC && !any_reset) |=> PREFETCH;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("no prefetch");
	property p_wake_fast;  // RQ20
		@(posedge CLK) disable iff (RST)
		(state_reg.mode == MODE_ASLEEP && wake_req && !any_reset && !state_reg.reg_low_power)
			|=> WDT_CLEAR ##1 (RESUME && CPU_CLK_EN && !PORT_HOLD);
	endproperty
	a_wake_fast: assert property (p_wake_fast) else $error("slow wake");
	property p_asleep_holds;  // RQ12
		@(posedge CLK) disable iff (RST)
		(state_reg.mode == MODE_ASLEEP) |-> (PORT_HOLD && !CPU_CLK_EN && LF_OSC_EN);
	endproperty
	a_asleep_holds: assert property (p_asleep_holds) else $error("sleep outputs wrong");
	property p_reset_acts;  // RQ13
		@(posedge CLK) disable iff (RST)
		any_reset |=> (CORE_RESET && state_reg.mode == MODE_AWAKE && CPU_CLK_EN);
	endproperty
	a_reset_acts: assert property (p_reset_acts) else $error("reset ignored");
	property p_defer_vector;  // RQ17
		@(posedge CLK) disable iff (RST)
		RESUME |-> !IRQ_REQ;
	endproperty
	a_defer_vector: assert property (p_defer_vector) else $error("vector too early");
	property p_vreg;  // RQ22
		@(posedge CLK) disable iff (RST)
		$rose(state_reg.mode == MODE_ASLEEP) |-> REG_LOW_POWER == state_reg.regulator_power_mode_select;
	endproperty
	a_vreg: assert property (p_vreg) else $error("regulator mode wrong");
endmodule : swif_top

/* File: testbench/swif_core_model.sv */
// behavioural core that issues sleep and retires the following instruction
module swif_core_model (
	input  wire logic clk,          // system clock
	input  wire logic rst,          // sync reset, high
	input  wire logic go,           // bench asks for a sleep instruction
	input  wire logic resume,       // block resumes execution
	output logic      sleep_exec,   // sleep instruction executing
	output logic      instr_retire  // instruction completed
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************************************
	// instruction stream
	// ********************************************************
	// one sleep pulse per request, one retire after each resume
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sleep_exec <= 1'b0;
			instr_retire <= 1'b0;
		end
		else
		begin
			sleep_exec <= go;
			instr_retire <= resume;
		end
	end
endmodule : swif_core_model

/* File: testbench/testbench.sv */
// self-checking bench for the sleep and wake flag block
module testbench
	import swif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 2;
	logic        CLK, RST, WB_CYC, WB_STB, WB_WE, WB_ACK, SLEEP_EXEC, INSTR_RETIRE;
	logic        EXT_IRQ_WAKE, WDT_TIMEOUT, WDT_SLEEP_RUN, PIN_RESET_REQ, BROWNOUT_REQ;
	logic        POWERON_REQ, ADC_OSC_SEL, CPU_CLK_EN, LF_OSC_EN, T1_CLK_EN, ADC_CLK_EN;
	logic        PORT_HOLD, REG_LOW_POWER, WDT_CLEAR, WDT_RUN, PREFETCH, RESUME;
	logic        CORE_RESET, IRQ_REQ, ASLEEP, go, pf, wc;
	logic [3:0]  WB_SEL;
	logic [7:0]  WB_ADR, ev;
	logic [1:0]  T1_CLK_SEL;
	logic [31:0] WB_DAT_I, WB_DAT_O;
	swif_evt_t   EVT;
	logic [7:0]  exp_q[$];
	int          num_errors, total_checks, n0, n1, i;
	swif_top #(.SETTLE_CNT(SC)) u_swif_top (
		.CLK(CLK), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
		.WB_SEL(WB_SEL), .WB_ADR(WB_ADR), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
		.WB_ACK(WB_ACK), .EVT(EVT), .SLEEP_EXEC(SLEEP_EXEC), .INSTR_RETIRE(INSTR_RETIRE),
		.EXT_IRQ_WAKE(EXT_IRQ_WAKE), .WDT_TIMEOUT(WDT_TIMEOUT), .WDT_SLEEP_RUN(WDT_SLEEP_RUN),
		.PIN_RESET_REQ(PIN_RESET_REQ), .BROWNOUT_REQ(BROWNOUT_REQ), .POWERON_REQ(POWERON_REQ),
		.T1_CLK_SEL(T1_CLK_SEL), .ADC_OSC_SEL(ADC_OSC_SEL), .CPU_CLK_EN(CPU_CLK_EN),
		.LF_OSC_EN(LF_OSC_EN), .T1_CLK_EN(T1_CLK_EN), .ADC_CLK_EN(ADC_CLK_EN),
		.PORT_HOLD(PORT_HOLD), .REG_LOW_POWER(REG_LOW_POWER), .WDT_CLEAR(WDT_CLEAR),
		.WDT_RUN(WDT_RUN), .PREFETCH(PREFETCH), .RESUME(RESUME), .CORE_RESET(CORE_RESET),
		.IRQ_REQ(IRQ_REQ), .ASLEEP(ASLEEP));
	swif_core_model u_swif_core_model (.clk(CLK), .rst(RST), .go(go), .resume(RESUME),
		.sleep_exec(SLEEP_EXEC), .instr_retire(INSTR_RETIRE));
	// ********************************************************
	// clock, compare and bus helpers
	// ********************************************************
	// free running clock
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// read results are matched against the oldest note
	always @(posedge CLK)
	begin
		if (WB_ACK === 1'b1 && WB_WE === 1'b0)
		begin
			if (exp_q.size() == 0)
				chk(WB_DAT_O, 32'hffffffff, "read without note");
			else
				chk(WB_DAT_O, {24'h0, exp_q.pop_front()}, "read data");
		end
	end
	// classic cycle; for a read d is the expected byte
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		if (!w)
			exp_q.push_back(d);
		WB_CYC <= 1'b1;
		WB_STB <= 1'b1;
		WB_WE <= w;
		WB_ADR <= a;
		WB_DAT_I <= {24'h0, d};
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (WB_ACK !== 1'b1 && n < 20);
		if (n >= 20)
			chk(1'b0, 1'b1, "no ack");
		WB_CYC <= 1'b0;
		WB_STB <= 1'b0;
		@(posedge CLK);
	endtask : bus
	task automatic rdflags(input logic [6:0] v);
		logic [23:0] f;
		f = {v[6], v[5], 4'h0, v[4], v[3], 5'h0, v[2], 2'h0, 6'h0, v[1], v[0]};
		for (int k = 0; k < 3; k++)
			bus(1'b0, OFS_FLAGS1 + 8'(4 * k), f[23 - 8 * k -: 8]);
	endtask : rdflags
	task automatic wr3(input logic [7:0] base, input logic [7:0] d);
		for (int k = 0; k < 3; k++)
			bus(1'b1, base + 8'(4 * k), d);
	endtask : wr3
	task automatic kick(input logic [6:0] v);
		EVT <= swif_evt_t'(v);
		@(posedge CLK);
		EVT <= '0;
	endtask : kick
	// sleep request, noting prefetch and watchdog clear
	task automatic do_sleep;
		pf = 1'b0;
		wc = 1'b0;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		repeat (3)
		begin
			@(posedge CLK);
			pf |= PREFETCH;
			wc |= WDT_CLEAR;
		end
	endtask : do_sleep
	task automatic wait_res(output int n);
		n = 0;
		wc = 1'b0;
		do
		begin
			@(posedge CLK);
			wc |= WDT_CLEAR;
			n++;
		end
		while (RESUME !== 1'b1 && n < 100);
		if (RESUME !== 1'b1)
			chk(1'b0, 1'b1, "no resume");
	endtask : wait_res
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	// ********************************************************
	// scenarios
	// ********************************************************
	// hang guard
	initial
	begin
		repeat (5000) @(posedge CLK);
		chk(1'b0, 1'b1, "timeout");
		final_report;
	end
	initial
	begin
		void'($urandom(32'ha99daf28));
		{RST, WB_SEL} = {1'b1, 4'h1};
		{WB_CYC, WB_STB, WB_WE, WB_ADR, WB_DAT_I, EVT, go} = '0;
		{EXT_IRQ_WAKE, WDT_TIMEOUT, WDT_SLEEP_RUN, PIN_RESET_REQ} = '0;
		{BROWNOUT_REQ, POWERON_REQ, T1_CLK_SEL, ADC_OSC_SEL} = 5'b00101;
		num_errors = 0;
		total_checks = 0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		bus(1'b0, OFS_STATUS, 8'h18);
		bus(1'b0, OFS_REGULATOR, 8'h01);
		bus(1'b0, 8'hfc, 8'h00);
		rdflags(7'h00);
		wr3(OFS_FLAGS1, 8'hff);
		rdflags(7'h7f);
		bus(1'b1, OFS_REGULATOR, 8'hfe);
		bus(1'b0, OFS_REGULATOR, 8'h03);
		wr3(OFS_FLAGS1, 8'h00);
		ev = 8'($urandom) | 8'h01;
		kick(ev[6:0]);
		rdflags(ev[6:0]);
		wr3(OFS_ENABLE1, 8'hff);
		do_sleep;
		chk(pf, 1'b1, "prefetch");
		chk({wc, ASLEEP}, 2'b00, "nop sleep");
		bus(1'b0, OFS_STATUS, 8'h18);
		wr3(OFS_ENABLE1, 8'h00);
		wr3(OFS_FLAGS1, 8'h00);
		bus(1'b1, OFS_ENABLE1, 8'h40);
		bus(1'b1, OFS_GLOBAL, 8'hc0);
		bus(1'b1, OFS_REGULATOR, 8'h01);
		do_sleep;
		chk({wc, WDT_RUN, ASLEEP}, 3'b101, "entry");
		chk({CPU_CLK_EN, LF_OSC_EN, PORT_HOLD}, 3'b011, "gates");
		chk({T1_CLK_EN, ADC_CLK_EN, REG_LOW_POWER}, 3'b110, "clocks");
		bus(1'b0, OFS_STATUS, 8'h10);
		kick(7'h20);
		wait_res(n0);
		chk({wc, CPU_CLK_EN, IRQ_REQ}, 3'b110, "wake");
		repeat (4) @(posedge CLK);
		chk(IRQ_REQ, 1'b1, "vector");
		bus(1'b1, OFS_GLOBAL, 8'h80);
		@(posedge CLK);
		chk(IRQ_REQ, 1'b0, "periph gate");
		bus(1'b1, OFS_FLAGS1, 8'h00);
		bus(1'b1, OFS_ENABLE1, 8'h01);
		bus(1'b1, OFS_REGULATOR, 8'h03);
		{T1_CLK_SEL, ADC_OSC_SEL} <= 3'b000;
		do_sleep;
		chk({REG_LOW_POWER, T1_CLK_EN, ADC_CLK_EN}, 3'b100, "low power");
		kick(7'h08);
		wait_res(n1);
		chk(n1, n0 + SC - 1, "settle");
		bus(1'b1, OFS_FLAGS1, 8'h00);
		WDT_SLEEP_RUN <= 1'b1;
		T1_CLK_SEL <= 2'd1;
		do_sleep;
		chk({WDT_RUN, T1_CLK_EN}, 2'b11, "wdt run");
		WDT_TIMEOUT <= 1'b1;
		@(posedge CLK);
		WDT_TIMEOUT <= 1'b0;
		wait_res(n1);
		chk(wc, 1'b1, "wdt wake clear");
		bus(1'b0, OFS_STATUS, 8'h00);
		// each reset source while asleep
		for (i = 0; i < 3; i++)
		begin
			do_sleep;
			PIN_RESET_REQ <= (i == 0);
			BROWNOUT_REQ <= (i == 1);
			POWERON_REQ <= (i == 2);
			@(posedge CLK);
			{PIN_RESET_REQ, BROWNOUT_REQ, POWERON_REQ} <= 3'h0;
			pf = 1'b0;
			repeat (3)
			begin
				@(posedge CLK);
				pf |= CORE_RESET;
			end
			chk({pf, ASLEEP}, 2'b10, "reset wake");
			bus(1'b0, OFS_STATUS, 8'h18);
		end
		kick(7'h7f);
		do_sleep;
		repeat (5) @(posedge CLK);
		chk(ASLEEP, 1'b1, "disabled flags");
		EXT_IRQ_WAKE <= 1'b1;
		wait_res(n1);
		chk({CPU_CLK_EN, IRQ_REQ}, 2'b10, "ext wake");
		EXT_IRQ_WAKE <= 1'b0;
		repeat (2) @(posedge CLK);
		final_report;
	end
endmodule : testbench
